// [ext_code_fetch_page_bus.sv]
`include "ext_code_fetch_params.svh"
`default_nettype none
module ext_code_fetch_page_bus (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Configuration
    input wire logic pageModeEn,
    input wire logic [1:0] pageTimingSel,
    input wire logic execInternal,
    input wire logic runEn,
    // Core requests
    input wire logic jumpValid,
    input wire logic [15:0] jumpAddr,
    input wire logic [1:0] descBytes,
    input wire logic [3:0] descCycles,
    input wire logic descSfrCheck,
    // Fetch results
    output var logic byteValid,
    output var logic [7:0] byteData,
    output ext_code_fetch_pkg::byte_kind_type byteKind,
    output logic pageMiss,
    // Internal code memory
    output logic [15:0] intCodeAddr,
    input wire logic [7:0] intCodeData,
    // External code bus pins
    output logic [7:0] upperPortOut,
    output logic upperPortOe,
    input wire logic [7:0] lowerPortIn,
    output logic [7:0] lowerPortOut,
    output logic lowerPortOe,
    output logic addrLatchStrobe,
    output logic codeReadEnableN
);
    import ext_code_fetch_pkg::*;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic isSpecial(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        unique case (a)
            `ADDR_STATUS_WORD, `ADDR_STACK_PTR, `ADDR_PTR_SELECT,
            `ADDR_IRQ_ENABLE, `ADDR_EXT_IRQ_ENABLE, `ADDR_IRQ_PRIO0,
            `ADDR_IRQ_PRIO1, `ADDR_EXT_IRQ_PRIO0,
            `ADDR_EXT_IRQ_PRIO1: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic [3:0] hitLength(
        input bus_mode_type m,
        input logic [1:0] sel
    );
        logic [3:0] len;
        len = `LEN_NONPAGE;
        unique case (m)
            MODE_INTERNAL: len = `LEN_INTERNAL;
            MODE_NONPAGE: len = `LEN_NONPAGE;
            MODE_PAGE1: begin
                if (sel == `SEL_4CYC) begin
                    len = `LEN_HIT4;
                end else if (sel == `SEL_2CYC) begin
                    len = `LEN_HIT2;
                end else begin
                    len = `LEN_HIT1;
                end
            end
            default: len = `LEN_NONPAGE;
        endcase
        return len;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    seq_state_type state_q;
    bus_mode_type mode_q;
    bus_mode_type modeNext;
    logic [15:0] pc_q;
    logic [15:0] pcNext;
    logic [15:0] addr_q;
    logic [7:0] lastHi_q;
    logic hiValid_q;
    logic miss_q;
    logic missNext;
    logic [3:0] clk_q;
    logic [3:0] len_q;
    logic [3:0] hitLen_q;
    logic [3:0] hitLenNext;
    logic [3:0] lenNext;
    logic [1:0] realLeft_q;
    logic [3:0] stallLeft_q;
    logic sfrPending_q;
    logic [1:0] realEff;
    logic [3:0] stallEff;
    logic [3:0] descStall;
    logic descTake;
    logic extraNow;
    logic cycEnd;
    logic setupNow;
    byte_kind_type kindNow;

    assign cycEnd = (state_q == ST_CYCLE) && (clk_q == len_q - 4'h1);
    assign setupNow = runEn && ((state_q == ST_IDLE) || cycEnd);

    // ----------------------------------------
    // Instruction accounting
    // ----------------------------------------
    assign descTake = byteValid && (byteKind == KIND_OPCODE);
    assign extraNow = byteValid && (byteKind == KIND_OPERAND)
        && sfrPending_q && isSpecial(byteData);

    always_comb begin
        descStall = 4'h0;
        if (descCycles > {2'h0, descBytes}) begin
            descStall = descCycles - {2'h0, descBytes};
        end
        realEff = descTake ? descBytes - 2'h1 : realLeft_q;
        stallEff = (descTake ? descStall : stallLeft_q) + {3'h0, extraNow};
        if (realEff != 2'h0) begin
            kindNow = KIND_OPERAND;
        end else if (stallEff != 4'h0) begin
            kindNow = KIND_DUMMY;
        end else begin
            kindNow = KIND_OPCODE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            realLeft_q <= 2'h0;
            stallLeft_q <= 4'h0;
        end else begin
            realLeft_q <= (cycEnd && kindNow == KIND_OPERAND) ? realEff - 2'h1 : realEff;
            stallLeft_q <= (cycEnd && kindNow == KIND_DUMMY) ? stallEff - 4'h1 : stallEff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sfrPending_q <= 1'b0;
        end else if (descTake) begin
            sfrPending_q <= descSfrCheck;
        end else if (byteValid && byteKind == KIND_OPERAND) begin
            sfrPending_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    always_comb begin
        pcNext = pc_q;
        if (jumpValid) begin
            pcNext = jumpAddr;
        end else if (cycEnd && kindNow != KIND_DUMMY) begin
            pcNext = pc_q + 16'h0001;
        end
    end

    // Dummy cycles hold the PC, so a stall after a page's last byte
    // already addresses the next page and classifies as a miss.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc_q <= `PC_RESET;
        end else begin
            pc_q <= pcNext;
        end
    end

    // ----------------------------------------
    // Next memory cycle setup
    // ----------------------------------------
    always_comb begin
        if (execInternal) begin
            modeNext = MODE_INTERNAL;
        end else if (pageModeEn && pageTimingSel != `SEL_UNUSED) begin
            modeNext = MODE_PAGE1;
        end else begin
            modeNext = MODE_NONPAGE;
        end
        hitLenNext = hitLength(modeNext, pageTimingSel);
        missNext = (modeNext == MODE_PAGE1)
            && (!hiValid_q || pcNext[15:8] != lastHi_q);
        lenNext = missNext ? {hitLenNext[2:0], 1'b0} : hitLenNext;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else if (setupNow) begin
            state_q <= ST_CYCLE;
        end else if (cycEnd) begin
            state_q <= ST_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_q <= MODE_NONPAGE;
            addr_q <= `PC_RESET;
            len_q <= `LEN_NONPAGE;
            hitLen_q <= `LEN_NONPAGE;
            miss_q <= 1'b0;
        end else if (setupNow) begin
            mode_q <= modeNext;
            addr_q <= pcNext;
            len_q <= lenNext;
            hitLen_q <= hitLenNext;
            miss_q <= missNext;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            clk_q <= 4'h0;
        end else if (setupNow) begin
            clk_q <= 4'h0;
        end else if (state_q == ST_CYCLE) begin
            clk_q <= clk_q + 4'h1;
        end
    end

    // The external latch keeps its high byte only while page mode runs;
    // a non-page cycle overwrites it, and every non-page or internal cycle clears hiValid_q, so the next page cycle must miss.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lastHi_q <= 8'h00;
            hiValid_q <= 1'b0;
        end else if (setupNow) begin
            lastHi_q <= pcNext[15:8];
            hiValid_q <= (modeNext == MODE_PAGE1);
        end
    end

    // ----------------------------------------
    // Fetched byte delivery
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            byteValid <= 1'b0;
            byteData <= 8'h00;
            byteKind <= KIND_DUMMY;
        end else begin
            byteValid <= cycEnd;
            if (cycEnd) begin
                byteData <= (mode_q == MODE_INTERNAL) ? intCodeData : lowerPortIn;
                byteKind <= kindNow;
            end
        end
    end

    // ----------------------------------------
    // Pin waveforms
    // ----------------------------------------
    logic active;
    logic addrPhase;
    logic [3:0] hitPos;
    logic [3:0] half;
    logic [3:0] aleEnd;

    assign active = (state_q == ST_CYCLE);
    assign addrPhase = miss_q && (clk_q < hitLen_q);
    assign hitPos = miss_q ? clk_q - hitLen_q : clk_q;
    assign half = hitLen_q >> 1;
    assign aleEnd = (half == 4'h0) ? 4'h1 : half;
    assign pageMiss = active && miss_q;
    assign intCodeAddr = addr_q;

    always_comb begin
        upperPortOut = 8'h00;
        upperPortOe = 1'b0;
        lowerPortOut = 8'h00;
        lowerPortOe = 1'b0;
        addrLatchStrobe = 1'b0;
        codeReadEnableN = 1'b1;
        if (active && mode_q == MODE_NONPAGE) begin
            upperPortOut = addr_q[15:8];
            upperPortOe = 1'b1;
            lowerPortOut = addr_q[7:0];
            lowerPortOe = (clk_q < `NP_ADDR_CLKS);
            addrLatchStrobe = (clk_q == 4'h0);
            codeReadEnableN = (clk_q < `NP_ADDR_CLKS);
        end else if (active && mode_q == MODE_PAGE1) begin
            upperPortOut = addrPhase ? addr_q[15:8] : addr_q[7:0];
            upperPortOe = 1'b1;
            addrLatchStrobe = addrPhase && (clk_q < aleEnd);
            // With a one-clock hit, half is zero and the enable stays low
            // through back-to-back hits instead of toggling.
            codeReadEnableN = addrPhase || (hitPos < half);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    np_strobe_len_a: assert property (@(posedge core_clk) disable iff (reset)
        (active && mode_q == MODE_NONPAGE && addrLatchStrobe)
        |-> ##1 (!addrLatchStrobe) [*3]
        ##1 (!active || mode_q != MODE_NONPAGE || addrLatchStrobe))
        else $error("non-page cycle strobe spacing wrong");
    reset_mode_a: assert property (@(posedge core_clk) disable iff (reset)
        (setupNow && !pageModeEn) |=> mode_q != MODE_PAGE1)
        else $error("page mode entered without enable");
    hit4_len_a: assert property (@(posedge core_clk) disable iff (reset)
        (setupNow && modeNext == MODE_PAGE1 && pageTimingSel == `SEL_4CYC)
        |=> len_q == (miss_q ? 4'h8 : 4'h4))
        else $error("four-clock page cycle length wrong");
    hit2_len_a: assert property (@(posedge core_clk) disable iff (reset)
        (setupNow && modeNext == MODE_PAGE1 && pageTimingSel == `SEL_2CYC)
        |=> len_q == (miss_q ? 4'h4 : 4'h2))
        else $error("two-clock page cycle length wrong");
    hit1_len_a: assert property (@(posedge core_clk) disable iff (reset)
        (setupNow && modeNext == MODE_PAGE1 && pageTimingSel == `SEL_1CYC)
        |=> len_q == (miss_q ? 4'h2 : 4'h1))
        else $error("one-clock page cycle length wrong");
    hit1_enable_a: assert property (@(posedge core_clk) disable iff (reset)
        (active && mode_q == MODE_PAGE1 && hitLen_q == 4'h1 && !miss_q)
        |-> !codeReadEnableN)
        else $error("read enable not held low on one-clock hit");
    miss_strobe_a: assert property (@(posedge core_clk) disable iff (reset)
        (active && mode_q == MODE_PAGE1 && clk_q == 4'h0)
        |-> addrLatchStrobe == miss_q)
        else $error("page strobe does not follow miss");
    internal_len_a: assert property (@(posedge core_clk) disable iff (reset)
        (setupNow && execInternal) |=> len_q == 4'h1 ##1 (!active || clk_q == 4'h0))
        else $error("internal cycle not one clock");
    stall_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        (cycEnd && kindNow == KIND_DUMMY && !jumpValid) |=> pc_q == $past(pc_q))
        else $error("program counter moved on dummy fetch");
    page_lower_a: assert property (@(posedge core_clk) disable iff (reset)
        (active && mode_q == MODE_PAGE1) |-> !lowerPortOe)
        else $error("lower port driven in page mode");
    sfr_extra_a: assert property (@(posedge core_clk) disable iff (reset)
        (extraNow && !cycEnd) |=> stallLeft_q == $past(stallLeft_q) + 4'h1)
        else $error("special register stall not added");
    hit_class_a: assert property (@(posedge core_clk) disable iff (reset)
        (setupNow && modeNext == MODE_PAGE1 && hiValid_q && pcNext[15:8] == lastHi_q)
        |=> !miss_q)
        else $error("same page fetch classed as miss");
endmodule
`default_nettype wire

// [ext_code_fetch_page_bus_bench.sv]
`include "ext_code_fetch_params.svh"
`default_nettype none
module ext_code_fetch_page_bus_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import ext_code_fetch_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic pageModeEn = 1'b0;
    logic [1:0] pageTimingSel = 2'h2;
    logic execInternal = 1'b0;
    logic runEn = 1'b0;
    logic jumpValid = 1'b0;
    logic [15:0] jumpAddr = 16'h0000;
    logic [1:0] descBytes = 2'h1;
    logic [3:0] descCycles = 4'h1;
    logic descSfrCheck = 1'b0;
    logic byteValid, pageMiss, upperPortOe, lowerPortOe, addrLatchStrobe, codeReadEnableN;
    logic [7:0] byteData, intCodeData, upperPortOut, lowerPortIn, lowerPortOut;
    logic [15:0] intCodeAddr;
    byte_kind_type byteKind;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0, rises = 0, hiN = 0, oeCnt = 0, drvN = 0, missN = 0;
    logic prevStb = 1'b0;
    int evCyc[$], evRise[$], evHiN[$], evOe[$], evDrv[$], evMiss[$];
    logic [7:0] evData[$];
    byte_kind_type evKind[$];
    always #25 core_clk = ~core_clk;
    assign intCodeData = intCodeAddr[7:0] ^ 8'h5A;
    ext_code_fetch_page_bus i_dut (
        .core_clk(core_clk), .reset(reset), .pageModeEn(pageModeEn),
        .pageTimingSel(pageTimingSel), .execInternal(execInternal), .runEn(runEn),
        .jumpValid(jumpValid), .jumpAddr(jumpAddr), .descBytes(descBytes),
        .descCycles(descCycles), .descSfrCheck(descSfrCheck), .byteValid(byteValid),
        .byteData(byteData), .byteKind(byteKind), .pageMiss(pageMiss),
        .intCodeAddr(intCodeAddr), .intCodeData(intCodeData), .upperPortOut(upperPortOut),
        .upperPortOe(upperPortOe), .lowerPortIn(lowerPortIn), .lowerPortOut(lowerPortOut),
        .lowerPortOe(lowerPortOe), .addrLatchStrobe(addrLatchStrobe),
        .codeReadEnableN(codeReadEnableN)
    );
    ext_code_mem_model i_mem (
        .core_clk(core_clk), .pageMode(pageModeEn), .upperPortOut(upperPortOut),
        .lowerPortOut(lowerPortOut), .addrLatchStrobe(addrLatchStrobe),
        .codeReadEnableN(codeReadEnableN), .lowerPortIn(lowerPortIn)
    );
    // ----------------------------------------
    // Monitor: snapshots are taken before this edge's counts are added
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (byteValid === 1'b1) begin
            evCyc.push_back(cyc);
            evRise.push_back(rises);
            evHiN.push_back(hiN);
            evOe.push_back(oeCnt);
            evDrv.push_back(drvN);
            evMiss.push_back(missN);
            evData.push_back(byteData);
            evKind.push_back(byteKind);
        end
        cyc++;
        rises += int'(addrLatchStrobe === 1'b1 && prevStb !== 1'b1);
        hiN += int'(codeReadEnableN !== 1'b0);
        oeCnt += int'(lowerPortOe !== 1'b0);
        drvN += int'(upperPortOe === 1'b1);
        missN += int'(pageMiss === 1'b1);
        prevStb = addrLatchStrobe;
    end
    // ----------------------------------------
    // Compare and sequencing helpers
    // ----------------------------------------
    task automatic tally(input bit ok, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (!ok) begin
            mismatches++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic checkN(input int got, input int exp);
        tally(got == exp, 16'(got), 16'(exp));
    endtask
    task automatic checkB(input logic [7:0] got, input logic [7:0] exp);
        tally(got === exp, {8'h00, got}, {8'h00, exp});
    endtask
    task automatic checkK(input byte_kind_type got, input byte_kind_type exp);
        tally(got === exp, {13'h0000, got}, {13'h0000, exp});
    endtask
    function automatic logic [7:0] memb(input logic [15:0] a);
        return a[7:0] ^ a[15:8];
    endfunction
    function automatic int gap(input int i);
        return evCyc[i] - evCyc[i - 1];
    endfunction
    task automatic desc(input logic [1:0] b, input logic [3:0] c, input logic s);
        descBytes = b;
        descCycles = c;
        descSfrCheck = s;
    endtask
    task automatic waitN(input int n);
        int t = 0;
        while (evCyc.size() < n && t < 500) begin
            @(negedge core_clk);
            t++;
        end
        checkN(evCyc.size() >= n, 1);
    endtask
    // Mode changes only while idle; the bus is drained first
    task automatic run(input logic en, input logic intl, input logic [1:0] sel,
                       input logic [15:0] a, input int n);
        runEn = 1'b0;
        repeat (20) @(negedge core_clk);
        // Reset clears operands and stalls left over from the last run
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        execInternal = 1'b1;
        pageTimingSel = sel;
        @(negedge core_clk);
        pageModeEn = en;
        @(negedge core_clk);
        execInternal = intl;
        jumpAddr = a;
        jumpValid = 1'b1;
        @(negedge core_clk);
        jumpValid = 1'b0;
        evCyc.delete();
        evRise.delete();
        evHiN.delete();
        evOe.delete();
        evDrv.delete();
        evMiss.delete();
        evData.delete();
        evKind.delete();
        runEn = 1'b1;
        waitN(n);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_nonpage();
        desc(2'h1, 4'h1, 1'b0);
        run(1'b0, 1'b0, 2'h2, 16'h01FE, 4);
        for (int i = 1; i < 4; i++) begin
            checkN(gap(i), 4);
            checkN(evRise[i] - evRise[i - 1], 1);
        end
        checkN(evDrv[3] - evDrv[0], 12);
        for (int i = 0; i < 4; i++)
            checkB(evData[i], memb(16'h01FE + 16'(i)));
    endtask
    task automatic t_page(input logic [1:0] sel, input int l);
        desc(2'h1, 4'h1, 1'b0);
        run(1'b1, 1'b0, sel, 16'h12FE, 5);
        checkN(gap(1), l);
        checkN(gap(2), 2 * l);
        checkN(gap(3), l);
        checkN(evRise[1] - evRise[0], 0);
        checkN(evRise[2] - evRise[1], 1);
        checkN(evHiN[4] - evHiN[3], l / 2);
        checkN(evOe[4] - evOe[0], 0);
        checkN(evDrv[4] - evDrv[0], 5 * l);
        checkN(evMiss[1] - evMiss[0], 0);
        checkN(evMiss[2] - evMiss[1], 2 * l);
        for (int i = 0; i < 5; i++)
            checkB(evData[i], memb(16'h12FE + 16'(i)));
    endtask
    task automatic t_stall();
        desc(2'h1, 4'h2, 1'b0);
        run(1'b1, 1'b0, 2'h2, 16'h20FE, 4);
        checkK(evKind[1], KIND_DUMMY);
        checkK(evKind[2], KIND_OPCODE);
        checkB(evData[2], memb(16'h20FF));
        checkN(gap(3), 8);
        checkN(evRise[3] - evRise[2], 1);
    endtask
    task automatic t_mul();
        desc(2'h1, 4'h9, 1'b0);
        run(1'b1, 1'b0, 2'h0, 16'h4010, 10);
        for (int i = 1; i < 9; i++)
            checkK(evKind[i], KIND_DUMMY);
        checkK(evKind[9], KIND_OPCODE);
        checkB(evData[9], memb(16'h4011));
        checkN(evCyc[9] - evCyc[0], 9);
    endtask
    task automatic t_jbc();
        desc(2'h3, 4'h4, 1'b0);
        run(1'b1, 1'b0, 2'h0, 16'h4100, 5);
        checkK(evKind[1], KIND_OPERAND);
        checkK(evKind[2], KIND_OPERAND);
        checkK(evKind[3], KIND_DUMMY);
        checkK(evKind[4], KIND_OPCODE);
    endtask
    // Last entry is an ordinary port address that needs no extra cycle
    task automatic t_sfr();
        logic [7:0] adr[10] = '{`ADDR_STATUS_WORD, `ADDR_STACK_PTR, `ADDR_PTR_SELECT,
            `ADDR_IRQ_ENABLE, `ADDR_EXT_IRQ_ENABLE, `ADDR_IRQ_PRIO0, `ADDR_IRQ_PRIO1,
            `ADDR_EXT_IRQ_PRIO0, `ADDR_EXT_IRQ_PRIO1, 8'h90};
        desc(2'h2, 4'h2, 1'b1);
        for (int i = 0; i < 10; i++) begin
            run(1'b1, 1'b0, i[0] ? 2'h2 : 2'h0, {8'h00, adr[i]} - 16'h0001, 3);
            checkK(evKind[2], i < 9 ? KIND_DUMMY : KIND_OPCODE);
        end
    endtask
    task automatic t_ret(input logic [15:0] tgt, input int len);
        desc(2'h1, 4'h3, 1'b0);
        run(1'b1, 1'b0, 2'h2, 16'h5010, 2);
        jumpAddr = tgt;
        jumpValid = 1'b1;
        @(negedge core_clk);
        jumpValid = 1'b0;
        waitN(4);
        checkK(evKind[2], KIND_DUMMY);
        checkN(gap(3), len);
        checkB(evData[3], memb(tgt));
    endtask
    task automatic t_internal();
        desc(2'h1, 4'h1, 1'b0);
        run(1'b0, 1'b1, 2'h2, 16'h0300, 4);
        for (int i = 1; i < 4; i++)
            checkN(gap(i), 1);
        for (int i = 0; i < 4; i++)
            checkB(evData[i], 8'(i) ^ 8'h5A);
        checkN(evRise[3] - evRise[0], 0);
        checkN(evDrv[3] - evDrv[0], 0);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        t_nonpage();
        t_page(2'h2, 4);
        t_page(2'h1, 2);
        t_page(2'h0, 1);
        t_stall();
        t_mul();
        t_jbc();
        t_sfr();
        t_ret(16'h5080, 4);
        t_ret(16'h6080, 8);
        t_internal();
        stop_test();
    end
    // Run needs about 800 cycles; the limit allows far more
    initial begin
        #2000000;
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire

// [ext_code_fetch_params.svh]
`ifndef EXT_CODE_FETCH_PARAMS_SVH
`define EXT_CODE_FETCH_PARAMS_SVH
// ----------------------------------------
// Memory cycle lengths in system clocks
// ----------------------------------------
`define LEN_INTERNAL 4'h1
`define LEN_NONPAGE 4'h4
`define LEN_HIT4 4'h4
`define LEN_HIT2 4'h2
`define LEN_HIT1 4'h1
// ----------------------------------------
// Non-page waveform points
// ----------------------------------------
`define NP_ADDR_CLKS 4'h2
// ----------------------------------------
// Page timing select codes
// ----------------------------------------
`define SEL_4CYC 2'h2
`define SEL_2CYC 2'h1
`define SEL_1CYC 2'h0
`define SEL_UNUSED 2'h3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PC_RESET 16'h0000
// ----------------------------------------
// Direct addresses of the slow special registers
// ----------------------------------------
`define ADDR_STATUS_WORD 8'hD0
`define ADDR_STACK_PTR 8'h81
`define ADDR_PTR_SELECT 8'h86
`define ADDR_IRQ_ENABLE 8'hA8
`define ADDR_EXT_IRQ_ENABLE 8'hE8
`define ADDR_IRQ_PRIO0 8'hB8
`define ADDR_IRQ_PRIO1 8'hB1
`define ADDR_EXT_IRQ_PRIO0 8'hF8
`define ADDR_EXT_IRQ_PRIO1 8'hF1
`endif

// [ext_code_fetch_pkg.sv]
`default_nettype none
package ext_code_fetch_pkg;
    typedef enum logic [2:0] {
        MODE_INTERNAL = 3'b001,
        MODE_NONPAGE = 3'b010,
        MODE_PAGE1 = 3'b100
    } bus_mode_type;
    typedef enum logic [2:0] {
        KIND_OPCODE = 3'b001,
        KIND_OPERAND = 3'b010,
        KIND_DUMMY = 3'b100
    } byte_kind_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CYCLE = 2'b10
    } seq_state_type;
endpackage
`default_nettype wire

// [ext_code_mem_model.sv]
`default_nettype none
module ext_code_mem_model (
    // Clock and bus mode
    input wire logic core_clk,
    input wire logic pageMode,
    // Bus pins
    input wire logic [7:0] upperPortOut,
    input wire logic [7:0] lowerPortOut,
    input wire logic addrLatchStrobe,
    input wire logic codeReadEnableN,
    output logic [7:0] lowerPortIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] latchQ = 8'h00;
    logic [7:0] lastQ = 8'h00;
    logic [15:0] addr;
    // ----------------------------------------
    // Address latch and code array
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (addrLatchStrobe) begin
            latchQ <= pageMode ? upperPortOut : lowerPortOut;
        end
        if (!codeReadEnableN) begin
            lastQ <= lowerPortIn;
        end
    end
    assign addr = pageMode ? {latchQ, upperPortOut} : {upperPortOut, latchQ};
    // Inverted last byte while disabled, so a late sample never looks right
    assign lowerPortIn = codeReadEnableN ? ~lastQ : addr[7:0] ^ addr[15:8];
endmodule
`default_nettype wire
